// file: common/fsl_pkg.sv
`default_nettype none
package fsl_pkg;
	localparam int unsigned CLK_HZ   = 40000000;
	localparam int unsigned RATE_BPS = 614400;
	localparam int unsigned BIT_CYC  = CLK_HZ / RATE_BPS;
	localparam logic [6:0]  BIT_LAST = 7'(BIT_CYC - 1);
	localparam logic [6:0]  BIT_HALF = 7'(BIT_CYC / 2);
	localparam int unsigned MS_US    = 1000;
	localparam int unsigned MS_CYC   = CLK_HZ / 1000000 * MS_US;
	localparam int unsigned LOSS_MS  = 2000;
	localparam int unsigned LOSS_CYC = MS_CYC * LOSS_MS;
	localparam int unsigned RESP_MAX_MS = 4;
	localparam int unsigned PROC_MAX_MS = 70;
	localparam logic [7:0]  FLAG_BYTE  = 8'h7e;
	localparam logic [15:0] CRC_POLY_R = 16'h8408;
	localparam logic [15:0] CRC_INIT   = 16'hffff;
	localparam logic [15:0] CRC_GOOD   = 16'hf0b8;
	localparam logic [2:0]  ONES_STUFF = 3'd5;
	localparam logic [2:0]  ONES_FLAG  = 3'd6;
	localparam logic [2:0]  ONES_SAT   = 3'd7;
	localparam logic [2:0]  BIT_MSB    = 3'd7;
	localparam logic [7:0]  T_STATUS = 8'h31;
	localparam logic [7:0]  T_MC     = 8'h32;
	localparam logic [7:0]  T_RAW    = 8'h34;
	localparam logic [7:0]  T_SETOUT = 8'h37;
	localparam logic [7:0]  T_VRAW   = 8'h3f;
	localparam logic [7:0]  T_VOUT   = 8'h40;
	localparam logic [7:0]  RESP_BIT = 8'h80;
	localparam int          IN_BYTES  = 8;
	localparam int          OUT_BYTES = 8;
	localparam logic [7:0]  VOUT_N    = 8'(2 * OUT_BYTES);
	localparam int          BUF_DEPTH = 21;
	localparam int          PAY_MAX   = 16;
	localparam logic [4:0]  LEN_MAX    = 5'(BUF_DEPTH);
	localparam logic [4:0]  LEN_MIN    = 5'd4;
	localparam logic [4:0]  LEN_STATUS = 5'd5;
	localparam logic [4:0]  LEN_MC     = 5'd8;
	localparam logic [4:0]  LEN_POLL   = 5'd4;
	localparam logic [4:0]  LEN_SETOUT = 5'd20;
	localparam logic [4:0]  LEN_VOUT   = 5'd21;
	localparam logic [4:0]  RL_STATUS = 5'd9;
	localparam logic [4:0]  RL_MC     = 5'd3;
	localparam logic [4:0]  RL_RAW    = 5'd14;
	localparam logic [4:0]  RL_VRAW   = 5'd15;
	localparam logic [4:0]  RL_SHORT  = 5'd2;
	localparam logic [5:0]  M_ERR_EDGES = 6'd60;
	localparam logic [8:0]  L_ERR_TICKS = 9'd500;
	localparam logic [7:0]  A_CTRL = 8'h00;
	localparam logic [7:0]  A_STAT = 8'h04;
	localparam logic [7:0]  A_EVT  = 8'h08;
	localparam logic [7:0]  A_TS   = 8'h0c;
	localparam int          CTRL_ABORT = 8;
	localparam logic [7:0]  OWN_ADDR_RST = 8'h00;
	localparam logic [7:0]  FLAGS_RST    = 8'hc0;
	typedef struct packed {
		logic p;
		logic e;
		logic k;
		logic r;
		logic t;
		logic m;
		logic l;
		logic w;
	} fsl_flags_t;
	typedef struct packed {
		logic abort_rx;
		logic crc_err;
		logic addr_hit;
	} fsl_evt_t;
endpackage
`default_nettype wire

// file: logic/fsl_crc_byte.sv
`default_nettype none
module fsl_crc_byte (
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc_out
);
	import fsl_pkg::*;
	// Reflected, lsb first, one byte per cycle
	always_comb begin
		crc_out = crc_in;
		for (int i = 0; i < 8; i++) begin
			if (crc_out[0] ^ data[i])
				crc_out = (crc_out >> 1) ^ CRC_POLY_R;
			else
				crc_out = crc_out >> 1;
		end
	end
endmodule // fsl_crc_byte
`default_nettype wire

// file: logic/fsl_link.sv
`default_nettype none
module fsl_link #(
	parameter logic [15:0] MS_CYCLES   = 16'(fsl_pkg::MS_CYC),
	parameter logic [26:0] LOSS_CYCLES = 27'(fsl_pkg::LOSS_CYC)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_rx,
	output logic             link_tx,
	output logic             link_tx_oe_n,
	input  wire logic        linesync,
	input  wire logic        key_ok,
	input  wire logic        wdog_rst,
	input  wire logic [63:0] raw_in,
	output logic      [63:0] field_out
);
	import fsl_pkg::*;

	typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DATA, TX_FCS, TX_CLOSE, TX_ABORT} fsl_tx_t;

	logic [1:0]  rx_s_q, ls_s_q, key_s_q, wd_s_q;
	logic [63:0] in_s1_q, in_s2_q;
	logic        rx_d_q, ls_d_q;
	logic [6:0]  rx_ph_q, tx_ph_q;
	logic [2:0]  r_ones_q, r_bit_q;
	logic [7:0]  r_sh_q;
	logic [4:0]  r_n_q;
	logic        r_in_q;
	logic [15:0] r_crc_q, r_crc_o;
	logic [7:0]  buf_q [BUF_DEPTH];
	fsl_tx_t     t_st_q;
	logic [7:0]  t_sh_q, t_nb;
	logic [2:0]  t_bit_q, t_ones_q;
	logic [4:0]  t_idx_q, t_ni, resp_len;
	logic [15:0] t_crc_q, t_crc_i, t_crc_o;
	logic        t_hi_q, t_go_q, a_go_q;
	logic [7:0]  resp_ty_q, own_addr_q, rxc_q, txc_q, rxc_snap_q, txc_snap_q;
	logic [7:0]  pay [PAY_MAX];
	fsl_flags_t  fl_q, fl_set, fl_clr, fl_snap_q;
	fsl_evt_t    ev_q, ev_set;
	logic [31:0] mc_q, mc_new_q, ts_snap_q, rd;
	logic        mc_pend_q, loss_q;
	logic [15:0] ms_div_q;
	logic [26:0] loss_cnt_q;
	logic [5:0]  m_cnt_q;
	logic [8:0]  l_cnt_q;
	logic [63:0] in_snap_q, out_dat_q, out_ctl_q;
	logic        len_ok, rd_hit;

	wire b       = rx_s_q[1];
	wire ls      = ls_s_q[1];
	wire ls_rise = ls & ~ls_d_q;
	wire ls_edge = ls ^ ls_d_q;
	wire rx_samp = rx_ph_q == BIT_HALF;
	wire tx_en   = tx_ph_q == BIT_LAST;
	wire ms_tick = ms_div_q == MS_CYCLES - 16'd1;
	wire [7:0] cmd = buf_q[1];

	// Two flops on every pin outside the register bus before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s_q  <= 2'b11;
			ls_s_q  <= 2'b00;
			key_s_q <= 2'b11; // Idle level of the pin, no false key fault
			wd_s_q  <= 2'b00;
			in_s1_q <= 64'h0;
			in_s2_q <= 64'h0;
			rx_d_q  <= 1'b1;
			ls_d_q  <= 1'b0;
		end else begin
			rx_s_q  <= {rx_s_q[0], link_rx};
			ls_s_q  <= {ls_s_q[0], linesync};
			key_s_q <= {key_s_q[0], key_ok};
			wd_s_q  <= {wd_s_q[0], wdog_rst};
			in_s1_q <= raw_in;
			in_s2_q <= in_s1_q;
			rx_d_q  <= rx_s_q[1];
			ls_d_q  <= ls_s_q[1];
		end
	end

	// Bit timing; receive phase follows line edges since no clock travels with data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ph_q <= 7'd0;
			tx_ph_q <= 7'd0;
		end else begin
			rx_ph_q <= (b ^ rx_d_q || rx_ph_q == BIT_LAST) ? 7'd0 : rx_ph_q + 7'd1;
			tx_ph_q <= tx_en ? 7'd0 : tx_ph_q + 7'd1;
		end
	end

	// Receive bit classification; idle ones after a closing flag are no abort
	wire r_dbit  = rx_samp && r_in_q && (b ? r_ones_q < ONES_FLAG : r_ones_q < ONES_STUFF);
	wire r_flag  = rx_samp && !b && r_ones_q == ONES_FLAG;
	wire r_abort = rx_samp && b && r_ones_q == ONES_FLAG && r_in_q && r_n_q != 5'd0;
	wire r_fin   = r_flag && r_in_q && r_n_q != 5'd0;
	wire r_shape = r_bit_q == BIT_MSB && r_n_q >= LEN_MIN && r_n_q <= LEN_MAX;
	wire r_crcok = r_crc_q == CRC_GOOD;
	wire r_hit   = r_fin && r_shape && r_crcok && buf_q[0] == own_addr_q;
	wire rx_err  = (r_fin && !(r_shape && r_crcok)) || r_abort;
	wire exec    = r_hit && len_ok && t_st_q == TX_IDLE && !t_go_q;
	wire [7:0] r_byte = {b, r_sh_q[7:1]};

	fsl_crc_byte u_rx_crc (
		.crc_in  (r_crc_q),
		.data    (r_byte),
		.crc_out (r_crc_o)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ones_q <= ONES_SAT;
			r_bit_q  <= 3'd0;
			r_sh_q   <= 8'h00;
			r_n_q    <= 5'd0;
			r_in_q   <= 1'b0;
			r_crc_q  <= CRC_INIT;
		end else if (rx_samp) begin
			if (b)
				r_ones_q <= (r_ones_q == ONES_SAT) ? ONES_SAT : r_ones_q + 3'd1;
			else
				r_ones_q <= 3'd0;
			if (r_flag) begin
				r_in_q  <= 1'b1;
				r_bit_q <= 3'd0;
				r_n_q   <= 5'd0;
				r_crc_q <= CRC_INIT;
			end else if (b && r_ones_q == ONES_FLAG) begin
				r_in_q <= 1'b0;
			end else if (r_dbit) begin
				r_sh_q  <= r_byte;
				r_bit_q <= r_bit_q + 3'd1;
				if (r_bit_q == BIT_MSB) begin
					r_crc_q <= r_crc_o;
					r_n_q   <= (r_n_q == 5'h1f) ? r_n_q : r_n_q + 5'd1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_q[i] <= 8'h00;
		end else if (r_dbit && r_bit_q == BIT_MSB && r_n_q < LEN_MAX) begin
			buf_q[r_n_q] <= r_byte;
		end
	end

	// Exact length per type; diagnostic and unlisted types fall to default
	always_comb begin
		case (cmd)
		T_STATUS: len_ok = r_n_q == LEN_STATUS;
		T_MC:     len_ok = r_n_q == LEN_MC;
		T_RAW:    len_ok = r_n_q == LEN_POLL;
		T_VRAW:   len_ok = r_n_q == LEN_POLL;
		T_SETOUT: len_ok = r_n_q == LEN_SETOUT;
		T_VOUT:   len_ok = r_n_q == LEN_VOUT && buf_q[2] == VOUT_N;
		default:  len_ok = 1'b0;
		endcase
	end

	// Flags; a set in the same cycle as its clear wins
	assign fl_clr = (exec && cmd == T_STATUS) ? fsl_flags_t'(buf_q[2]) : fsl_flags_t'(8'h00);
	always_comb begin
		fl_set   = fsl_flags_t'(8'h00);
		fl_set.e = loss_cnt_q == LOSS_CYCLES - 27'd1;
		fl_set.k = !key_s_q[1];
		fl_set.r = rx_err && rxc_q == 8'hff;
		fl_set.t = tx_en && t_st_q == TX_IDLE && a_go_q && txc_q == 8'hff;
		fl_set.m = ls_edge && m_cnt_q == M_ERR_EDGES - 6'd1;
		fl_set.l = ms_tick && l_cnt_q == L_ERR_TICKS - 9'd1;
		fl_set.w = wd_s_q[1];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fl_q <= fsl_flags_t'(FLAGS_RST);
		else
			fl_q <= (fl_q & ~fl_clr) | fl_set;
	end

	// Counters only ever count up and wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxc_q <= 8'h00;
			txc_q <= 8'h00;
		end else begin
			if (rx_err)
				rxc_q <= rxc_q + 8'd1;
			if (tx_en && t_st_q == TX_IDLE && a_go_q)
				txc_q <= txc_q + 8'd1;
		end
	end

	// Snapshot at command acceptance so answers stay stable while shifting out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_ty_q  <= 8'h00;
			fl_snap_q  <= fsl_flags_t'(8'h00);
			rxc_snap_q <= 8'h00;
			txc_snap_q <= 8'h00;
			ts_snap_q  <= 32'h0;
			in_snap_q  <= 64'h0;
			mc_new_q   <= 32'h0;
		end else if (exec) begin
			resp_ty_q  <= cmd;
			fl_snap_q  <= (fl_q & ~fl_clr) | fl_set;
			rxc_snap_q <= rxc_q;
			txc_snap_q <= txc_q;
			ts_snap_q  <= mc_q;
			in_snap_q  <= in_s2_q;
			if (cmd == T_MC)
				mc_new_q <= {buf_q[2], buf_q[3], buf_q[4], buf_q[5]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_dat_q <= 64'h0;
			out_ctl_q <= 64'h0;
		end else if (exec && (cmd == T_SETOUT || cmd == T_VOUT)) begin
			for (int i = 0; i < OUT_BYTES; i++) begin
				out_dat_q[i*8 +: 8] <= buf_q[2 + i + int'(cmd == T_VOUT)];
				out_ctl_q[i*8 +: 8] <= buf_q[2 + OUT_BYTES + i + int'(cmd == T_VOUT)];
			end
		end
	end

	// Millisecond counter, load waits for the line rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_div_q  <= 16'd0;
			mc_q      <= 32'h0;
			mc_pend_q <= 1'b0;
		end else begin
			ms_div_q <= ms_tick ? 16'd0 : ms_div_q + 16'd1;
			if (ls_rise && mc_pend_q)
				mc_q <= mc_new_q;
			else if (ms_tick)
				mc_q <= mc_q + 32'd1;
			if (exec && cmd == T_MC)
				mc_pend_q <= 1'b1;
			else if (ls_rise)
				mc_pend_q <= 1'b0;
		end
	end

	// Watch ticks against line edges and the reverse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_cnt_q <= 6'd0;
			l_cnt_q <= 9'd0;
		end else begin
			if (ms_tick)
				m_cnt_q <= 6'd0;
			else if (ls_edge && m_cnt_q != M_ERR_EDGES)
				m_cnt_q <= m_cnt_q + 6'd1;
			if (ls_edge)
				l_cnt_q <= 9'd0;
			else if (ms_tick && l_cnt_q != L_ERR_TICKS)
				l_cnt_q <= l_cnt_q + 9'd1;
		end
	end

	// Comms loss; outputs stay dark until the first good frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_cnt_q <= 27'd0;
			loss_q     <= 1'b1;
		end else if (r_hit) begin
			loss_cnt_q <= 27'd0;
			loss_q     <= 1'b0;
		end else if (loss_cnt_q != LOSS_CYCLES - 27'd1) begin
			loss_cnt_q <= loss_cnt_q + 27'd1;
		end else begin
			loss_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			field_out <= 64'h0;
		else
			field_out <= {64{~loss_q}} & ((out_dat_q & ~out_ctl_q) |
				(out_ctl_q & (out_dat_q ^ {64{ls}})));
	end

	// Response payload, bytes after address and type
	always_comb begin
		for (int j = 0; j < PAY_MAX; j++)
			pay[j] = 8'h00;
		case (resp_ty_q)
		T_STATUS: begin
			pay[0] = fl_snap_q;
			pay[1] = rxc_snap_q;
			pay[2] = txc_snap_q;
			for (int j = 0; j < 4; j++)
				pay[3 + j] = ts_snap_q[31 - 8*j -: 8];
		end
		T_RAW, T_VRAW: begin
			if (resp_ty_q == T_VRAW)
				pay[0] = 8'(IN_BYTES);
			for (int j = 0; j < IN_BYTES; j++)
				pay[j + int'(resp_ty_q == T_VRAW)] = in_snap_q[j*8 +: 8];
			for (int j = 0; j < 4; j++)
				pay[IN_BYTES + j + int'(resp_ty_q == T_VRAW)] = ts_snap_q[31 - 8*j -: 8];
		end
		default: ;
		endcase
	end

	always_comb begin
		case (resp_ty_q)
		T_STATUS: resp_len = RL_STATUS;
		T_MC:     resp_len = RL_MC;
		T_RAW:    resp_len = RL_RAW;
		T_VRAW:   resp_len = RL_VRAW;
		default:  resp_len = RL_SHORT;
		endcase
	end

	assign t_ni    = (t_st_q == TX_OPEN) ? 5'd0 : t_idx_q + 5'd1;
	assign t_crc_i = (t_st_q == TX_OPEN) ? CRC_INIT : t_crc_q;
	always_comb begin
		if (t_ni == 5'd0)
			t_nb = own_addr_q;
		else if (t_ni == 5'd1)
			t_nb = resp_ty_q | RESP_BIT;
		else
			t_nb = pay[4'(t_ni - 5'd2)];
	end

	fsl_crc_byte u_tx_crc (
		.crc_in  (t_crc_i),
		.data    (t_nb),
		.crc_out (t_crc_o)
	);

	// Start requests; answer goes out at the next bit slot, or after a pending abort, far inside 4 ms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t_go_q <= 1'b0;
		else if (exec)
			t_go_q <= 1'b1;
		else if (tx_en && t_st_q == TX_IDLE && !a_go_q)
			t_go_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_st_q    <= TX_IDLE;
			t_sh_q    <= 8'hff;
			t_bit_q   <= 3'd0;
			t_idx_q   <= 5'd0;
			t_ones_q  <= 3'd0;
			t_crc_q   <= CRC_INIT;
			t_hi_q    <= 1'b0;
			link_tx      <= 1'b1;
			link_tx_oe_n <= 1'b1;
		end else if (tx_en) begin
			case (t_st_q)
			TX_IDLE: begin
				link_tx      <= 1'b1;
				link_tx_oe_n <= 1'b1;
				t_bit_q      <= 3'd0;
				if (a_go_q)
					t_st_q <= TX_ABORT;
				else if (t_go_q) begin
					t_st_q <= TX_OPEN;
					t_sh_q <= FLAG_BYTE;
				end
			end
			TX_OPEN, TX_ABORT: begin
				link_tx_oe_n <= 1'b0;
				link_tx      <= (t_st_q == TX_ABORT) | t_sh_q[0];
				t_sh_q       <= t_sh_q >> 1;
				t_bit_q      <= t_bit_q + 3'd1;
				if (t_bit_q == BIT_MSB) begin
					if (t_st_q == TX_ABORT)
						t_st_q <= TX_IDLE;
					else begin
						t_st_q   <= TX_DATA;
						t_sh_q   <= t_nb;
						t_crc_q  <= t_crc_o;
						t_idx_q  <= 5'd0;
						t_ones_q <= 3'd0;
					end
				end
			end
			TX_DATA, TX_FCS, TX_CLOSE: begin
				link_tx_oe_n <= 1'b0;
				if (t_ones_q == ONES_STUFF) begin
					link_tx  <= 1'b0;
					t_ones_q <= 3'd0;
				end else begin
					link_tx  <= t_sh_q[0];
					t_sh_q   <= t_sh_q >> 1;
					t_bit_q  <= t_bit_q + 3'd1;
					t_ones_q <= (t_sh_q[0] && t_st_q != TX_CLOSE) ? t_ones_q + 3'd1 : 3'd0;
					if (t_bit_q == BIT_MSB) begin
						case (t_st_q)
						TX_DATA: begin
							if (t_idx_q + 5'd1 < resp_len) begin
								t_sh_q  <= t_nb;
								t_crc_q <= t_crc_o;
								t_idx_q <= t_idx_q + 5'd1;
							end else begin
								t_st_q <= TX_FCS;
								t_sh_q <= ~t_crc_q[7:0];
								t_hi_q <= 1'b0;
							end
						end
						TX_FCS: begin
							if (!t_hi_q) begin
								t_sh_q <= ~t_crc_q[15:8];
								t_hi_q <= 1'b1;
							end else begin
								t_st_q <= TX_CLOSE;
								t_sh_q <= FLAG_BYTE;
							end
						end
						default: t_st_q <= TX_IDLE;
						endcase
					end
				end
			end
			default: t_st_q <= TX_IDLE;
			endcase
		end
	end

	// Register bus: two-cycle access, reply registered
	wire apb_req = psel && penable && !pready;
	wire apb_wr  = psel && penable && pready && pwrite;

	always_comb begin
		rd_hit = 1'b1;
		case (paddr)
		A_CTRL:  rd = {23'h0, a_go_q, own_addr_q};
		A_STAT:  rd = {7'h0, loss_q, txc_q, rxc_q, fl_q};
		A_EVT:   rd = {29'h0, ev_q};
		A_TS:    rd = mc_q;
		default: begin
			rd     = 32'h0;
			rd_hit = 1'b0;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_req;
			if (apb_req) begin
				prdata  <= pwrite ? 32'h0 : rd;
				pslverr <= !rd_hit;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			own_addr_q <= OWN_ADDR_RST;
		else if (apb_wr && paddr == A_CTRL)
			own_addr_q <= pwdata[7:0];
	end

	// Abort request; a new write beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			a_go_q <= 1'b0;
		else if (apb_wr && paddr == A_CTRL && pwdata[CTRL_ABORT])
			a_go_q <= 1'b1;
		else if (tx_en && t_st_q == TX_IDLE)
			a_go_q <= 1'b0;
	end

	always_comb begin
		ev_set          = fsl_evt_t'(3'b000);
		ev_set.addr_hit = r_hit;
		ev_set.crc_err  = r_fin && r_shape && !r_crcok;
		ev_set.abort_rx = r_abort;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ev_q <= fsl_evt_t'(3'b000);
		else if (apb_wr && paddr == A_EVT)
			ev_q <= (ev_q & ~fsl_evt_t'(pwdata[2:0])) | ev_set;
		else
			ev_q <= ev_q | ev_set;
	end
endmodule // fsl_link
`default_nettype wire

// file: tb/fsl_cpu_model.sv
`default_nettype none
module fsl_cpu_model (
	input  wire logic pclk,
	input  wire logic line_in,
	output logic      line_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import fsl_pkg::*;
	int ones;
	initial line_out = 1'b1;
	task automatic bit_out(input logic b);
		line_out <= b;
		repeat (BIT_CYC) @(posedge pclk);
	endtask
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
			for (int k = 0; k < 8; k++)
				c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? 16'h8408 : 16'h0000);
		return c;
	endfunction
	// Only the CPU end opens an exchange
	task automatic send(input logic [7:0] q[$], input logic bad, input logic abrt);
		logic [15:0] c;
		c = ~crc(q) ^ {15'h0, bad};
		if (!abrt) begin
			q.push_back(c[7:0]);
			q.push_back(c[15:8]);
		end
		for (int k = 0; k < 8; k++) bit_out(FLAG_BYTE[k]);
		ones = 0;
		foreach (q[i])
			for (int k = 0; k < 8; k++) begin
				bit_out(q[i][k]);
				ones = q[i][k] ? ones + 1 : 0;
				if (ones == 5) begin
					bit_out(1'b0);
					ones = 0;
				end
			end
		for (int k = 0; k < 8; k++) bit_out(abrt | FLAG_BYTE[k]);
		line_out <= 1'b1;
	endtask
	task automatic recv(output logic [7:0] q[$]);
		logic [7:0] sh;
		logic       bits[$];
		int         w;
		q = {};
		bits = {};
		w = 0;
		while (line_in && w < 400) begin
			@(posedge pclk);
			w++;
		end
		if (line_in) return;
		repeat (BIT_CYC / 2) @(posedge pclk);
		ones = 0;
		for (int g = 0; g < 4000; g++) begin
			if (line_in) begin
				ones++;
				bits.push_back(1'b1);
			end else if (ones == 5)
				ones = 0;
			else begin
				if (ones == 6)
					repeat (7) void'(bits.pop_back());
				else
					bits.push_back(1'b0);
				if (ones == 6 && bits.size() > 0) break;
				ones = 0;
			end
			repeat (BIT_CYC) @(posedge pclk);
		end
		for (int i = 0; i + 8 <= bits.size(); i += 8) begin
			for (int k = 0; k < 8; k++) sh[k] = bits[i + k];
			q.push_back(sh);
		end
	endtask
endmodule // fsl_cpu_model
`default_nettype wire

// file: tb/fsl_link_chk.sv
`default_nettype none
module fsl_link_chk #(
	parameter logic [15:0] MS_CYCLES   = 16'd40,
	parameter logic [26:0] LOSS_CYCLES = 27'd2000
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        link_tx,
	input wire logic        link_tx_oe_n,
	input wire logic [63:0] field_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import fsl_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Saturates so a stuck line cannot wrap
	logic [11:0] run_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_q <= '0;
		else if (link_tx && !link_tx_oe_n)
			run_q <= run_q + 12'(run_q != 12'hfff);
		else
			run_q <= '0;
	end
	property p_idle; link_tx_oe_n |-> link_tx; endproperty
	a_idle: assert property (p_idle) else $error("line not idle high");
	property p_flag; $fell(link_tx_oe_n) && !link_tx |-> ##64 !link_tx ##1 link_tx; endproperty
	a_flag: assert property (p_flag) else $error("bad opening flag");
	property p_stuff; !link_tx_oe_n && $fell(link_tx) |-> run_q <= 12'd390; endproperty
	a_stuff: assert property (p_stuff) else $error("ones run too long");
	property p_abort; $rose(link_tx_oe_n) && run_q > 12'd390 |-> run_q >= 12'd520; endproperty
	a_abort: assert property (p_abort) else $error("abort too short");
	property p_rdy; psel && penable && !pready |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_err;
		pready && (paddr > 8'h0c || paddr[1:0] != 2'd0) |-> pslverr && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access accepted");
	property p_loss;
		pready && !pwrite && paddr == A_STAT && prdata[24] |-> field_out == 64'h0;
	endproperty
	a_loss: assert property (p_loss) else $error("outputs on during loss");
endmodule // fsl_link_chk
bind fsl_link fsl_link_chk #(.MS_CYCLES(MS_CYCLES), .LOSS_CYCLES(LOSS_CYCLES)) fsl_link_chk_i (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.link_tx, .link_tx_oe_n, .field_out);
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fsl_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        lsync = 0, key_ok = 1, wdog = 0, rx, er, ls_run = 1;
	logic [7:0]  paddr = '0, ad;
	logic [31:0] pwdata = '0, prdata, rd, v, lfsr = 32'd93439;
	logic [63:0] raw_in = '0, field_out, dat;
	logic        pready, pslverr, link_tx, link_tx_oe_n;
	logic [7:0]  q[$], r[$];
	int          err_total = 0, checked = 0;
	always #12.5 pclk = ~pclk;
	always begin
		repeat (1000) @(posedge pclk);
		lsync <= ls_run & ~lsync;
	end
	fsl_link #(.MS_CYCLES(16'd40), .LOSS_CYCLES(27'd16000)) fsl_link_i (.pclk, .presetn,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link_rx(rx),
		.link_tx, .link_tx_oe_n, .linesync(lsync), .key_ok, .wdog_rst(wdog), .raw_in,
		.field_out);
	fsl_cpu_model fsl_cpu_model_i (.pclk, .line_in(link_tx_oe_n | link_tx), .line_out(rx));
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic xchg(input logic [7:0] a, input logic bad, input logic ab);
		q.push_front(a);
		fsl_cpu_model_i.send(q, bad, ab);
		fsl_cpu_model_i.recv(r);
		if (r.size() > 0) chk(32'(fsl_cpu_model_i.crc(r)), 32'h0000f0b8);
		$display("exchange type %h done, %0d bytes back", q[1], r.size());
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		raw_in <= {rnd(), rnd()};
		ad = 8'(rnd());
		@(posedge pclk);
		apb(A_STAT, 1'b0, '0);
		chk(rd, 32'h010000c0);
		apb(8'h10, 1'b0, '0);
		chk({rd[30:0], er}, 32'h1);
		apb(A_CTRL, 1'b1, {24'h0, ad});
		wdog <= 1'b1;
		@(posedge pclk);
		wdog <= 1'b0;
		q = {T_STATUS, 8'h40};
		xchg(ad, 1'b0, 1'b0);
		chk({r[0], r[1], r[2], r[3]}, {ad, 8'hb1, 8'h81, 8'h00});
		chk(32'(r.size()), 32'd11);
		apb(A_EVT, 1'b1, 32'h7);
		q = {T_STATUS, 8'h00};
		xchg(~ad, 1'b0, 1'b0);
		apb(A_EVT, 1'b0, '0);
		chk(rd + 32'(r.size()), 32'h0);
		q = {T_STATUS, 8'h00};
		xchg(ad, 1'b1, 1'b0);
		apb(A_EVT, 1'b0, '0);
		chk(32'(rd[1]) + 32'(r.size()), 32'h1);
		q = {T_STATUS};
		xchg(ad, 1'b0, 1'b1);
		apb(A_EVT, 1'b0, '0);
		chk(32'(rd[2]) + 32'(r.size()), 32'h1);
		q = {8'h70};
		xchg(ad, 1'b0, 1'b0);
		chk(32'(r.size()), 32'h0);
		apb(A_EVT, 1'b0, '0);
		chk(rd, 32'h7);
		q = {T_STATUS, 8'hff};
		xchg(ad, 1'b0, 1'b0);
		chk({r[1], r[2], r[3], r[4]}, 32'hb1000200);
		q = {T_VRAW};
		xchg(ad, 1'b0, 1'b0);
		chk({r[1], r[2], r[3], r[10]}, {8'hbf, 8'h08, raw_in[7:0], raw_in[63:56]});
		chk(32'(r.size()), 32'd17);
		ls_run = 1'b0;
		v = rnd();
		q = {T_MC, v[31:24], v[23:16], v[15:8], v[7:0]};
		xchg(ad, 1'b0, 1'b0);
		chk({r[1], r[2]}, 32'hb200);
		ls_run = 1'b1;
		@(posedge lsync);
		repeat (4) @(posedge pclk);
		apb(A_TS, 1'b0, '0);
		chk(32'(rd - v < 32'd3), 32'h1);
		dat = {rnd(), rnd()};
		q = {T_SETOUT};
		for (int i = 0; i < 16; i++) q.push_back(i < 8 ? dat[8 * i +: 8] : 8'h00);
		xchg(ad, 1'b0, 1'b0);
		chk({r[1], field_out[23:0]}, {8'hb7, dat[23:0]});
		apb(A_CTRL, 1'b1, {23'h0, 1'b1, ad});
		repeat (800) @(posedge pclk);
		apb(A_STAT, 1'b0, '0);
		chk({rd[23:16], 7'h0, link_tx_oe_n}, 32'h0101);
		$display("abort send done");
		repeat (13000) @(posedge pclk);
		apb(A_STAT, 1'b0, '0);
		chk({rd[24], rd[6], field_out[7:0]}, 32'h300);
		$display("loss test done");
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
